// ### lpc_map.svh
// Constants of the low-power mode controller
// Operation
// R1 - Normal mode keeps analog powered between conversions, no wake delay.
// R2 - Key write to unlock address opens the power-control register.
// R3 - Light sleep enable set: conversion end with pin high enters light sleep.
// R4 - Light sleep during acquisition puts internal blocks in reduced power.
// R5 - Falling edge of convert pin leaves light sleep.
// R6 - Host waits light sleep wake interval before next conversion start.
// R7 - Deep sleep request set: next rising edge of pin enters deep sleep.
// R8 - Deep sleep powers off analog, keeps interface and registers.
// R9 - Ready indicator is high during deep sleep.
// R10 - Host writes zero to deep sleep request to leave deep sleep.
// R11 - Clearing deep sleep request drives ready indicator high.
// R12 - Host waits deep sleep wake interval before new conversion.
// R13 - Power-control writes without preceding unlock are ignored.
`ifndef LPC_MAP_SVH
`define LPC_MAP_SVH
// ==========================================================
// Register addresses and values
`define LPC_ADDR_W 8
`define LPC_UNLOCK_ADDR 8'h05
`define LPC_UNLOCK_KEY 8'h69
`define LPC_PWRCTL_ADDR 8'h04
`define LPC_LIGHT_BIT 0
`define LPC_DEEP_BIT 1
`define LPC_CTL_RESET 2'h0
// ==========================================================
// Timing
`define LPC_CLK_MHZ 25
`define LPC_CONV_NS 680
`define LPC_CONV_CYC ((`LPC_CONV_NS * `LPC_CLK_MHZ + 999) / 1000)
`endif

// ### lpc_pkg.sv
// Types of the low-power mode controller
package lpc_pkg;
  typedef enum logic [2:0] {
    LPC_IDLE, LPC_CONVERT, LPC_ACQUIRE, LPC_LIGHT, LPC_DEEP
  } lpc_state_type;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } lpc_write_type;
  typedef struct packed {
    logic analogOn;
    logic reducedPower;
    logic lightSleep;
    logic deepSleep;
  } lpc_power_type;
endpackage

// ### lpc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lpc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  initial begin
    if (WIDTH < 1) $error("lpc_sync: WIDTH must be at least 1");
  end
  // ==========================================================
  // Synchroniser chain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

// ### lpc_power_ctrl.sv
// Low-power mode controller top
`timescale 1ns/1ps
`include "lpc_map.svh"
module lpc_power_ctrl import lpc_pkg::*; #(
  parameter int CONV_CYCLES = `LPC_CONV_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic convertStartSelect,
  input wire lpc_write_type regWrite,
  output lpc_power_type power_q,
  output logic readyIndicator_q,
  output logic lightSleepEnable_q,
  output logic deepSleepRequest_q,
  output logic unlocked_q,
  output logic conversionDone_q
);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  initial begin
    if (CONV_CYCLES < 1) $error("lpc_power_ctrl: CONV_CYCLES must be at least 1");
  end

  lpc_state_type state_q;
  logic pinSync;
  logic pinPrev_q;
  logic pinRise;
  logic pinFall;
  logic [CW-1:0] convCnt_q;
  logic ctlWrite;
  logic deepClearEvt;

  // ==========================================================
  // Pin synchronisation and edges
  lpc_sync #(.WIDTH(1)) uSync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .asyncIn(convertStartSelect),
    .syncOut(pinSync)
  );
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) pinPrev_q <= 1'b0;
    else pinPrev_q <= pinSync;
  end
  assign pinRise = pinSync & ~pinPrev_q;
  assign pinFall = ~pinSync & pinPrev_q;

  // ==========================================================
  // Unlock key and power-control register
  assign ctlWrite = regWrite.valid && regWrite.addr == `LPC_PWRCTL_ADDR && unlocked_q; // R13
  assign deepClearEvt = ctlWrite && deepSleepRequest_q && !regWrite.data[`LPC_DEEP_BIT]; // R10
  // Unlock state: set by key, any other write relocks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      unlocked_q <= 1'b0;
    end else if (regWrite.valid) begin
      unlocked_q <= regWrite.addr == `LPC_UNLOCK_ADDR && regWrite.data == `LPC_UNLOCK_KEY; // R2
    end
  end
  // Mode selection bits, retained through deep sleep
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lightSleepEnable_q <= 1'(`LPC_CTL_RESET >> `LPC_LIGHT_BIT); // Reset value of the enable bit
      deepSleepRequest_q <= 1'b0;
    end else if (ctlWrite) begin // R13
      lightSleepEnable_q <= regWrite.data[`LPC_LIGHT_BIT];
      deepSleepRequest_q <= regWrite.data[`LPC_DEEP_BIT]; // R8
    end
  end

  // ==========================================================
  // Conversion timer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) convCnt_q <= '0;
    else if (state_q == LPC_CONVERT) convCnt_q <= convCnt_q + CW'(1);
    else convCnt_q <= '0;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) conversionDone_q <= 1'b0;
    else conversionDone_q <= state_q == LPC_CONVERT && convCnt_q == CW'(CONV_CYCLES - 1);
  end

  // ==========================================================
  // Mode state machine
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= LPC_IDLE;
    end else begin
      case (state_q)
        LPC_IDLE, LPC_ACQUIRE: begin
          if (pinRise && deepSleepRequest_q) state_q <= LPC_DEEP; // R7
          else if (pinRise) state_q <= LPC_CONVERT;
          else state_q <= LPC_ACQUIRE;
        end
        LPC_CONVERT: begin
          if (convCnt_q == CW'(CONV_CYCLES - 1)) begin
            if (pinSync && lightSleepEnable_q) state_q <= LPC_LIGHT; // R3
            else state_q <= LPC_ACQUIRE; // R1
          end
        end
        LPC_LIGHT: begin
          if (pinFall) state_q <= LPC_ACQUIRE; // R5
        end
        LPC_DEEP: begin
          if (deepClearEvt) state_q <= LPC_ACQUIRE; // R10
        end
        default: state_q <= LPC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Power outputs and ready indicator
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_q <= '{analogOn: 1'b1, reducedPower: 1'b0, lightSleep: 1'b0, deepSleep: 1'b0};
    end else begin
      power_q.analogOn <= !(state_q == LPC_DEEP && !deepClearEvt); // R8
      power_q.reducedPower <= state_q == LPC_LIGHT && !pinFall; // R4
      power_q.lightSleep <= state_q == LPC_LIGHT && !pinFall; // R3
      power_q.deepSleep <= state_q == LPC_DEEP && !deepClearEvt; // R8
    end
  end
  // Ready high in deep sleep and on recovery, low during conversion
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) readyIndicator_q <= 1'b1;
    else if (state_q == LPC_DEEP) readyIndicator_q <= 1'b1; // R9 R11
    else if (state_q == LPC_CONVERT) readyIndicator_q <= conversionDone_q;
    else readyIndicator_q <= 1'b1;
  end
endmodule

// ### lpc_props.sv
// Checker of the low-power mode controller
`timescale 1ns/1ps
module lpc_props import lpc_pkg::*; #(
  parameter int CONV_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic convertStartSelect,
  input wire lpc_write_type regWrite,
  input wire lpc_power_type power_q,
  input wire logic readyIndicator_q,
  input wire logic lightSleepEnable_q,
  input wire logic deepSleepRequest_q,
  input wire logic unlocked_q,
  input wire logic conversionDone_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // Write decode
  sequence sKey;
    regWrite.valid && regWrite.addr == 8'h05 && regWrite.data == 8'h69;
  endsequence
  sequence sCtl;
    regWrite.valid && regWrite.addr == 8'h04;
  endsequence
  // ==========
  // Checks
  a_unlock_key: assert property (sKey |=> unlocked_q)
    else $error("no unlock");
  a_locked_ignore: assert property ((sCtl ##0 !unlocked_q) |=>
    $stable({deepSleepRequest_q, lightSleepEnable_q})) else $error("locked write");
  a_ctl_write: assert property ((sCtl ##0 unlocked_q) |=>
    {deepSleepRequest_q, lightSleepEnable_q} == $past(regWrite.data[1:0])) else $error("ctl");
  a_light_enter: assert property (conversionDone_q && convertStartSelect &&
    lightSleepEnable_q |-> ##[0:3] power_q.lightSleep) else $error("no light");
  a_light_reduced: assert property (power_q.lightSleep |-> power_q.reducedPower)
    else $error("not reduced");
  a_light_exit: assert property ($fell(convertStartSelect) && power_q.lightSleep
    |-> ##[2:7] !power_q.lightSleep) else $error("light stuck");
  a_deep_enter: assert property ($rose(convertStartSelect) && deepSleepRequest_q
    |-> ##[3:7] power_q.deepSleep) else $error("no deep");
  a_deep_state: assert property (power_q.deepSleep |->
    readyIndicator_q && !power_q.analogOn) else $error("deep");
  a_deep_exit: assert property ($fell(deepSleepRequest_q) && $past(power_q.deepSleep) |->
    ##[0:2] !power_q.deepSleep && readyIndicator_q) else $error("deep exit");
  a_normal_on: assert property (!power_q.deepSleep && !power_q.lightSleep |->
    power_q.analogOn) else $error("analog off");
endmodule
bind lpc_power_ctrl lpc_props #(.CONV_CYCLES(CONV_CYCLES)) u_lpc_props (.core_clk, .arst_n,
  .convertStartSelect, .regWrite, .power_q, .readyIndicator_q, .lightSleepEnable_q,
  .deepSleepRequest_q, .unlocked_q, .conversionDone_q);

// ### lpc_host.sv
// Host model driving the pin and register writes
`timescale 1ns/1ps
module lpc_host import lpc_pkg::*; (
  input wire logic core_clk,
  output logic convertStartSelect,
  output lpc_write_type regWrite
);
  // Idle levels
  initial begin
    convertStartSelect = 1'b0;
    regWrite = '{1'b0, 8'hFF, 8'hFF};
  end
  // One-cycle write, bus then left with junk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk);
    regWrite = '{1'b1, a, d};
    @(negedge core_clk);
    regWrite = '{1'b0, ~a, ~d};
  endtask
  task automatic pin(logic v);
    @(negedge core_clk);
    convertStartSelect = v;
  endtask
  // Wake interval before a new start
  task automatic hold;
    repeat (8) @(negedge core_clk);
  endtask
endmodule

// ### testbench.sv
// Testbench of the low-power mode controller
`timescale 1ns/1ps
module testbench import lpc_pkg::*; ;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic convertStartSelect;
  lpc_write_type regWrite;
  lpc_power_type power_q;
  logic readyIndicator_q, lightSleepEnable_q, deepSleepRequest_q, unlocked_q, conversionDone_q;
  int fail_count = 0;
  int comparisons = 0;
  // Clock and parts
  initial forever #20 core_clk = ~core_clk;
  lpc_power_ctrl #(.CONV_CYCLES(4)) u_lpc_power_ctrl (.core_clk, .arst_n, .convertStartSelect,
    .regWrite, .power_q, .readyIndicator_q, .lightSleepEnable_q, .deepSleepRequest_q,
    .unlocked_q, .conversionDone_q);
  lpc_host u_lpc_host (.core_clk, .convertStartSelect, .regWrite);
  // Compare and report
  task automatic chk(logic [3:0] seen, logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: value differs", $time);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Bounded wait on power bits
  task automatic waitPow(logic [3:0] m, logic [3:0] e);
    for (int n = 0; n < 40 && (power_q & m) !== e; n++) @(negedge core_clk);
    chk(power_q & m, e);
  endtask
  // Scenarios
  task automatic tLock;
    u_lpc_host.wr(8'h04, 8'h03);
    u_lpc_host.wr(8'h05, 8'h11);
    u_lpc_host.wr(8'h04, 8'h03);
    chk({1'b0, unlocked_q, deepSleepRequest_q, lightSleepEnable_q}, 4'h0);
  endtask
  task automatic tLight;
    u_lpc_host.wr(8'h05, 8'h69);
    chk({3'h0, unlocked_q}, 4'h1);
    u_lpc_host.wr(8'h04, 8'h01);
    u_lpc_host.pin(1'b1);
    repeat (4) @(negedge core_clk);
    chk({3'h0, readyIndicator_q}, 4'h0);
    repeat (3) @(negedge core_clk);
    chk({3'h0, conversionDone_q}, 4'h1);
    waitPow(4'h6, 4'h6);
    u_lpc_host.pin(1'b0);
    waitPow(4'hA, 4'h8);
    u_lpc_host.hold();
  endtask
  task automatic tDeep;
    u_lpc_host.wr(8'h05, 8'h69);
    u_lpc_host.wr(8'h04, 8'h02);
    u_lpc_host.pin(1'b1);
    waitPow(4'h9, 4'h1);
    chk({1'b0, readyIndicator_q, deepSleepRequest_q, lightSleepEnable_q}, 4'h6);
    u_lpc_host.wr(8'h05, 8'h69);
    u_lpc_host.wr(8'h04, 8'h00);
    waitPow(4'h9, 4'h8);
    chk({3'h0, readyIndicator_q}, 4'h1);
    u_lpc_host.hold();
    u_lpc_host.pin(1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    chk(power_q, 4'h8);
    tLock();
    tLight();
    tDeep();
    end_of_test();
  end
endmodule
